/* File: core/rcd_init_pkg.sv */
package rcd_init_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int CS_W    = 4;
    localparam int CKE_W   = 2;
    localparam int ODT_W   = 2;
    localparam int CA_W    = 8;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS      = 4000;
    localparam int STAB_INTERVAL_NS   = 6000;
    localparam int SETUP_INTERVAL_NS  = 100;
    localparam int RESET_LOW_MIN_NS   = 100;
    // Longest figure rounds down, least figures round up
    localparam int STAB_CYCLES  = (STAB_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
    localparam int SETUP_CYCLES = (SETUP_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESET_LOW_CYCLES =
        (RESET_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;
    // Input clock counts as stable after this many rising edges seen
    localparam int CLK_STABLE_EDGES = 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [CS_W-1:0]  CS_IDLE   = 4'hF;
    localparam logic [CKE_W-1:0] CKE_LOW   = 2'h0;
    localparam logic [ODT_W-1:0] ODT_LOW   = 2'h0;
    localparam logic [CA_W-1:0]  CA_CLEAR  = 8'h00;

    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_ARMED  = 2'b01,
        ST_STAB   = 2'b10,
        ST_ACTIVE = 2'b11
    } init_state_t;

    typedef enum logic [2:0] {
        CT_HOLD    = 3'b000,
        CT_SETUP   = 3'b001,
        CT_RELEASE = 3'b010,
        CT_STAB    = 3'b011,
        CT_RUN     = 3'b100
    } ctrl_state_t;

endpackage

/* File: core/rcd_link_if.sv */
`timescale 1ns/1ps
interface rcd_link_if;
    import rcd_init_pkg::*;
    logic             reset_b;
    logic             in_clk;
    logic [CS_W-1:0]  chip_select_inputs;
    logic             clock_enable_input_zero;
    logic             clock_enable_input_one;
    logic [ODT_W-1:0] termination_inputs;
    logic [CA_W-1:0]  ca_inputs;
    logic             side_a_clock_enable_out_zero;
    logic             side_a_clock_enable_out_one;
    logic             side_b_clock_enable_out_zero;
    logic             side_b_clock_enable_out_one;
    logic [ODT_W-1:0] termination_outputs;
    logic [CS_W-1:0]  chip_select_outputs;
    logic [CA_W-1:0]  ca_outputs;
    logic             float_oe;

    modport device (
        input  reset_b, in_clk, chip_select_inputs, clock_enable_input_zero,
               clock_enable_input_one, termination_inputs, ca_inputs,
        output side_a_clock_enable_out_zero, side_a_clock_enable_out_one,
               side_b_clock_enable_out_zero, side_b_clock_enable_out_one,
               termination_outputs, chip_select_outputs, ca_outputs, float_oe
    );
    modport controller (
        output reset_b, in_clk, chip_select_inputs, clock_enable_input_zero,
               clock_enable_input_one, termination_inputs, ca_inputs,
        input  side_a_clock_enable_out_zero, side_a_clock_enable_out_one,
               side_b_clock_enable_out_zero, side_b_clock_enable_out_one,
               termination_outputs, chip_select_outputs, ca_outputs, float_oe
    );
endinterface

/* File: core/rcd_reset_init.sv */
`timescale 1ns/1ps
module rcd_reset_init
    import rcd_init_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Link
    rcd_link_if.device link,
    // Status
    output logic      powered_down,
    output logic      link_active
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic       rst_meta;
    logic       rst_sync;
    logic       ck_meta;
    logic       ck_sync;
    logic       ck_prev;

    // Reset pin is asynchronous to everything, so two flops before use
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
            ck_meta  <= 1'b0;
            ck_sync  <= 1'b0;
            ck_prev  <= 1'b0;
        end else begin
            rst_meta <= link.reset_b;
            rst_sync <= rst_meta;
            ck_meta  <= link.in_clk;
            ck_sync  <= ck_meta;
            ck_prev  <= ck_sync;
        end
    end

    wire ck_rise = ck_sync & ~ck_prev;

    // ****************************************
    // Input clock presence detector
    // ****************************************
    logic [3:0] ck_edges;
    logic [3:0] next_ck_edges;

    always_comb begin
        next_ck_edges = ck_edges;
        if (ck_rise && ck_edges != 4'(CLK_STABLE_EDGES)) begin
            next_ck_edges = ck_edges + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ck_edges <= 4'h0;
        end else begin
            ck_edges <= next_ck_edges;
        end
    end

    wire ck_stable = (ck_edges == 4'(CLK_STABLE_EDGES));

    // ****************************************
    // Init sequencer
    // ****************************************
    init_state_t      state;
    init_state_t      next_state;
    logic [CNT_W-1:0] stab_cnt;
    logic [CNT_W-1:0] next_stab_cnt;
    logic             first_edge_seen;
    logic             next_first_edge_seen;

    always_comb begin
        next_state           = state;
        next_stab_cnt        = stab_cnt;
        next_first_edge_seen = first_edge_seen;
        if (!rst_sync) begin
            // Reset level overrides everything at any time
            next_state           = ST_RESET;
            next_stab_cnt        = '0;
            next_first_edge_seen = 1'b0;
        end else begin
            case (state)
                ST_RESET: begin
                    // Rises count from local reset on, whatever the link reset level was
                    if (ck_stable) begin
                        next_state = ST_STAB;
                    end else begin
                        next_state = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    // Released without a clock: wait for fresh low pulse
                    next_state = ST_ARMED;
                end
                ST_STAB: begin
                    if (ck_rise) begin
                        next_first_edge_seen = 1'b1;
                    end
                    if (stab_cnt == CNT_W'(STAB_CYCLES - 1)) begin
                        next_state = ST_ACTIVE;
                    end else begin
                        next_stab_cnt = stab_cnt + 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    next_state = ST_ACTIVE;
                end
                default: begin
                    next_state = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state           <= ST_RESET;
            stab_cnt        <= '0;
            first_edge_seen <= 1'b0;
        end else begin
            state           <= next_state;
            stab_cnt        <= next_stab_cnt;
            first_edge_seen <= next_first_edge_seen;
        end
    end

    // ****************************************
    // Capture register and output stage
    // ****************************************
    logic [CS_W-1:0]  cs_q;
    logic [CS_W-1:0]  next_cs_q;
    logic [CKE_W-1:0] cke_q;
    logic [CKE_W-1:0] next_cke_q;
    logic [ODT_W-1:0] odt_q;
    logic [ODT_W-1:0] next_odt_q;
    logic [CA_W-1:0]  ca_q;
    logic [CA_W-1:0]  next_ca_q;
    logic             oe_q;
    logic             next_oe_q;
    logic             pd_q;
    logic             next_pd_q;
    logic             act_q;
    logic             next_act_q;

    always_comb begin
        next_cs_q  = CS_IDLE;
        next_cke_q = CKE_LOW;
        next_odt_q = ODT_LOW;
        next_ca_q  = CA_CLEAR;
        next_oe_q  = 1'b0;
        next_pd_q  = 1'b1;
        next_act_q = 1'b0;
        if (!rst_sync) begin
            // Inputs not looked at; all state back to default
            next_cke_q = CKE_LOW;
            next_oe_q  = 1'b0;
            next_pd_q  = 1'b1;
        end else if (state == ST_STAB) begin
            next_pd_q  = 1'b0;
            next_oe_q  = 1'b1;
            next_cs_q  = CS_IDLE;
            // Follows only after a seen rise, so the low level always shows first
            next_odt_q = first_edge_seen ? link.termination_inputs : ODT_LOW;
        end else if (state == ST_ACTIVE) begin
            next_pd_q  = 1'b0;
            next_oe_q  = 1'b1;
            next_act_q = 1'b1;
            // Captured on input clock rise; held between edges
            next_cs_q  = ck_rise ? link.chip_select_inputs : cs_q;
            next_cke_q = ck_rise ? {link.clock_enable_input_one,
                                    link.clock_enable_input_zero} : cke_q;
            next_odt_q = ck_rise ? link.termination_inputs : odt_q;
            next_ca_q  = ck_rise ? link.ca_inputs : ca_q;
        end else begin
            next_pd_q  = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cs_q  <= CS_IDLE;
            cke_q <= CKE_LOW;
            odt_q <= ODT_LOW;
            ca_q  <= CA_CLEAR;
            oe_q  <= 1'b0;
            pd_q  <= 1'b1;
            act_q <= 1'b0;
        end else begin
            cs_q  <= next_cs_q;
            cke_q <= next_cke_q;
            odt_q <= next_odt_q;
            ca_q  <= next_ca_q;
            oe_q  <= next_oe_q;
            pd_q  <= next_pd_q;
            act_q <= next_act_q;
        end
    end

    // Clock enables always driven; the rest float when float_oe is low
    assign link.side_a_clock_enable_out_zero = cke_q[0];
    assign link.side_b_clock_enable_out_zero = cke_q[0];
    assign link.side_a_clock_enable_out_one  = cke_q[1];
    assign link.side_b_clock_enable_out_one  = cke_q[1];
    assign link.chip_select_outputs          = cs_q;
    assign link.termination_outputs          = odt_q;
    assign link.ca_outputs                   = ca_q;
    assign link.float_oe                     = oe_q;
    assign powered_down                      = pd_q;
    assign link_active                       = act_q;

endmodule

/* File: core/rcd_init_controller.sv */
`timescale 1ns/1ps
module rcd_init_controller
    import rcd_init_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // User side
    input  wire logic             start,
    input  wire logic [CS_W-1:0]  user_cs,
    input  wire logic [CKE_W-1:0] user_cke,
    input  wire logic [ODT_W-1:0] user_odt,
    input  wire logic [CA_W-1:0]  user_ca,
    output logic                  ready,
    // Link
    rcd_link_if.controller        link
);

    // ****************************************
    // Sequencer
    // ****************************************
    ctrl_state_t      state;
    ctrl_state_t      next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             ck;
    logic             next_ck;
    logic             rdy;
    logic             next_rdy;

    always_comb begin
        next_state = state;
        next_cnt   = cnt + 1'b1;
        next_ck    = ~ck;
        next_rdy   = 1'b0;
        case (state)
            CT_HOLD: begin
                // Reset held low long enough; clock already toggling
                if (start && cnt >= CNT_W'(RESET_LOW_CYCLES)) begin
                    next_state = CT_SETUP;
                    next_cnt   = '0;
                end
            end
            CT_SETUP: begin
                if (cnt == CNT_W'(SETUP_CYCLES)) begin
                    next_state = CT_STAB;
                    next_cnt   = '0;
                end
            end
            CT_STAB: begin
                if (cnt == CNT_W'(STAB_CYCLES + SETUP_CYCLES)) begin
                    next_state = CT_RUN;
                    next_rdy   = 1'b1;
                end
            end
            CT_RUN: begin
                next_cnt = cnt;
                next_rdy = 1'b1;
            end
            default: begin
                next_state = CT_HOLD;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state <= CT_HOLD;
            cnt   <= '0;
            ck    <= 1'b0;
            rdy   <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            ck    <= next_ck;
            rdy   <= next_rdy;
        end
    end

    wire running = (state == CT_RUN);

    // Reset is always a defined level, never left floating
    assign link.reset_b = (state != CT_HOLD) && (state != CT_SETUP);
    assign link.in_clk  = ck;
    assign link.chip_select_inputs      = running ? user_cs : CS_IDLE;
    assign link.clock_enable_input_zero = running ? user_cke[0] : 1'b0;
    assign link.clock_enable_input_one  = running ? user_cke[1] : 1'b0;
    assign link.termination_inputs      = user_odt;
    assign link.ca_inputs               = user_ca;
    assign ready = rdy;

endmodule

/* File: sim/rcd_reset_init_asserts.sv */
`timescale 1ns/1ps
module rcd_reset_init_asserts
    import rcd_init_pkg::*;
(
    // Clock and reset
    input wire logic             mclk,
    input wire logic             rst_b,
    // Link
    input wire logic             reset_b,
    input wire logic             in_clk,
    input wire logic [CS_W-1:0]  chip_select_inputs,
    input wire logic             clock_enable_input_zero,
    input wire logic             clock_enable_input_one,
    input wire logic             side_a_clock_enable_out_zero,
    input wire logic             side_a_clock_enable_out_one,
    input wire logic             side_b_clock_enable_out_zero,
    input wire logic             side_b_clock_enable_out_one,
    input wire logic [ODT_W-1:0] termination_outputs,
    input wire logic [CS_W-1:0]  chip_select_outputs,
    input wire logic             float_oe
);
    // ****************************************
    // Helpers
    // ****************************************
    logic [7:0]       low_cnt;
    logic [7:0]       next_low_cnt;
    logic [CNT_W-1:0] hi_cnt;
    logic [CNT_W-1:0] next_hi_cnt;
    logic             cke_out;

    assign cke_out = side_a_clock_enable_out_zero | side_a_clock_enable_out_one |
                     side_b_clock_enable_out_zero | side_b_clock_enable_out_one;

    // Saturates so a long hold never wraps back below the minimum
    always_comb begin
        next_low_cnt = 8'h00;
        next_hi_cnt  = '0;
        if (!reset_b) begin
            next_low_cnt = (low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01;
        end else begin
            next_hi_cnt = (hi_cnt == '1) ? hi_cnt : hi_cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            low_cnt <= 8'h00;
            // Saturated, so a local reset mid-run opens no new window
            hi_cnt  <= '1;
        end else begin
            low_cnt <= next_low_cnt;
            hi_cnt  <= next_hi_cnt;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_entry_float: assert property ($fell(reset_b) |-> ##5 (!float_oe && !cke_out))
        else $error("outputs not floated after link reset entry");
    a_held_quiet: assert property ((!reset_b) [*6] |-> (!float_oe && !cke_out))
        else $error("outputs active while link reset held");
    a_release_drive: assert property ($rose(reset_b) |-> ##[3:5] float_oe)
        else $error("outputs not driven after release");
    a_cs_high_reset: assert property (!reset_b |-> chip_select_inputs == CS_IDLE)
        else $error("chip select input low during link reset");
    a_cke_stab_low: assert property ($rose(reset_b) |->
        (!clock_enable_input_zero && !clock_enable_input_one) [*8])
        else $error("clock enable input high during stabilization");
    a_cke_whole_stab: assert property ((reset_b && hi_cnt < CNT_W'(STAB_CYCLES)) |->
        (!clock_enable_input_zero && !clock_enable_input_one))
        else $error("clock enable input high inside stabilization window");
    a_first_levels: assert property ($rose(float_oe) |->
        (termination_outputs == ODT_LOW && chip_select_outputs == CS_IDLE))
        else $error("wrong first levels after release");
    a_low_min_hold: assert property ($rose(reset_b) |-> low_cnt >= 8'(RESET_LOW_CYCLES))
        else $error("link reset released too early");
    a_clk_pre_rel: assert property ($rose(reset_b) |-> $past(in_clk) != $past(in_clk, 2))
        else $error("input clock still before release");

    c_release: cover property ($rose(float_oe));
    c_mid_run: cover property ($fell(reset_b) && float_oe);
    c_link_up: cover property ($rose(reset_b));
endmodule

/* File: sim/tb_rcd_reset_init.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %s exp=%h got=%h", nm, exp, got); end end
`define WAIT_FOR(cond, lim, nm) begin k = 0; while (!(cond) && k < lim) begin \
    @(posedge mclk); k++; end if (!(cond)) begin errors++; \
    $display("[FAIL] %s exp=1 got=0", nm); summarize(); end end
module tb_rcd_reset_init;
    import rcd_init_pkg::*;
    logic             mclk;
    logic             rst_b;
    logic             ctl_rst_b;
    logic             start;
    logic [CS_W-1:0]  user_cs;
    logic [CKE_W-1:0] user_cke;
    logic [ODT_W-1:0] user_odt;
    logic [CA_W-1:0]  user_ca;
    logic             ready;
    logic             powered_down;
    logic             link_active;
    int               errors;
    int               n_tests;
    int               k;

    rcd_link_if link ();
    rcd_reset_init u_rcd_reset_init (.mclk(mclk), .rst_b(rst_b), .link(link),
        .powered_down(powered_down), .link_active(link_active));
    rcd_init_controller u_rcd_init_controller (.mclk(mclk), .rst_b(ctl_rst_b),
        .start(start), .user_cs(user_cs), .user_cke(user_cke), .user_odt(user_odt),
        .user_ca(user_ca), .ready(ready), .link(link));
    rcd_reset_init_asserts u_rcd_reset_init_asserts (.mclk(mclk), .rst_b(rst_b),
        .reset_b(link.reset_b), .in_clk(link.in_clk),
        .chip_select_inputs(link.chip_select_inputs),
        .clock_enable_input_zero(link.clock_enable_input_zero),
        .clock_enable_input_one(link.clock_enable_input_one),
        .side_a_clock_enable_out_zero(link.side_a_clock_enable_out_zero),
        .side_a_clock_enable_out_one(link.side_a_clock_enable_out_one),
        .side_b_clock_enable_out_zero(link.side_b_clock_enable_out_zero),
        .side_b_clock_enable_out_one(link.side_b_clock_enable_out_one),
        .termination_outputs(link.termination_outputs),
        .chip_select_outputs(link.chip_select_outputs), .float_oe(link.float_oe));

    // ****************************************
    // Scenarios
    // ****************************************
    function automatic logic [3:0] cke_outs();
        return {link.side_a_clock_enable_out_zero, link.side_a_clock_enable_out_one,
                link.side_b_clock_enable_out_zero, link.side_b_clock_enable_out_one};
    endfunction

    // Quiet state, also used after a mid-run link reset with user inputs still busy
    task automatic t_reset_state();
        `CHK("cke_outs", 4'h0, cke_outs())
        `CHK("float_oe", 1'b0, link.float_oe)
        `CHK("ca_clear", CA_CLEAR, link.ca_outputs)
        `CHK("powered_down", 1'b1, powered_down)
        `CHK("link_active", 1'b0, link_active)
    endtask

    task automatic t_bring_up();
        start <= 1'b1;
        `WAIT_FOR(link.float_oe, 200, "float_oe")
        `CHK("odt_first", ODT_LOW, link.termination_outputs)
        `CHK("cs_first", CS_IDLE, link.chip_select_outputs)
        `CHK("powered_down", 1'b0, powered_down)
        `CHK("cke_outs", 4'h0, cke_outs())
        repeat (STAB_CYCLES - 8) @(posedge mclk);
        `CHK("early_active", 1'b0, link_active)
        `WAIT_FOR(link_active, 40, "link_active")
        `WAIT_FOR(ready, 100, "ready")
    endtask

    // Each clock enable bit lands on both sides of its own pair
    task automatic t_pass_data();
        logic [CKE_W-1:0] ckes [2];
        logic [3:0]       pair;
        ckes = '{2'h1, 2'h2};
        for (int i = 0; i < 2; i++) begin
            user_cke <= ckes[i];
            user_ca  <= 8'hA5 ^ {4{ckes[i]}};
            user_odt <= ckes[i];
            user_cs  <= 4'hE - {2'h0, ckes[i]};
            repeat (10) @(posedge mclk);
            pair = {ckes[i][0], ckes[i][1], ckes[i][0], ckes[i][1]};
            `CHK("ca_out", 8'hA5 ^ {4{ckes[i]}}, link.ca_outputs)
            `CHK("odt_follow", ckes[i], link.termination_outputs)
            `CHK("cs_out", 4'hE - {2'h0, ckes[i]}, link.chip_select_outputs)
            `CHK("cke_pair", pair, cke_outs())
        end
    endtask

    // Local reset with the link already up: too few rises are counted before release, so it stays parked
    task automatic t_park();
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (20) @(posedge mclk);
        `CHK("park_float", 1'b0, link.float_oe)
        `CHK("park_active", 1'b0, link_active)
        `CHK("park_cke", 4'h0, cke_outs())
    endtask

    task automatic t_reenter();
        ctl_rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        ctl_rst_b <= 1'b1;
        repeat (8) @(posedge mclk);
        t_reset_state();
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        errors    = 0;
        n_tests   = 0;
        rst_b     = 1'b0;
        ctl_rst_b = 1'b0;
        start     = 1'b0;
        user_cs   = CS_IDLE;
        user_cke  = CKE_LOW;
        user_odt  = ODT_LOW;
        user_ca   = CA_CLEAR;
        repeat (8) @(posedge mclk);
        rst_b     <= 1'b1;
        ctl_rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset_state();
        t_bring_up();
        t_pass_data();
        t_park();
        t_reenter();
        t_bring_up();
        t_pass_data();
        summarize();
    end
endmodule
